//--- hw/scl_config_logic.sv
`timescale 1ns/1ps
module scl_config_logic
    import scl_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire scl_pins_t pins,
    output logic [LOOP_W-1:0] loop_div_out,
    output logic [OUT_DIV_W-1:0] out_div_out,
    output logic pll_reference,
    output logic synth_clock_out,
    output logic synth_clock_out_n,
    output logic test_out
);

    // ==========================================
    // Pin synchronisers
    scl_pins_t meta_q;
    scl_pins_t sync_q;
    logic sclk_prev_q;
    logic sload_prev_q;
    logic pload_prev_q;

    // Idle values stand in for open pins during reset
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            meta_q <= PINS_IDLE;
            sync_q <= PINS_IDLE;
        end
        else
        begin
            meta_q <= pins;
            sync_q <= meta_q;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            sclk_prev_q <= 1'h0;
            sload_prev_q <= 1'h0;
            pload_prev_q <= 1'h1;
        end
        else
        begin
            sclk_prev_q <= sync_q.serial_clock;
            sload_prev_q <= sync_q.serial_load;
            pload_prev_q <= sync_q.parallel_load;
        end
    end

    logic sclk_rise;
    logic ser_open;
    logic par_open;
    assign sclk_rise = sync_q.serial_clock & ~sclk_prev_q;
    assign ser_open = sync_q.serial_load;
    assign par_open = ~sync_q.parallel_load;

    // ==========================================
    // Serial shift register
    logic [CFG_W-1:0] shreg_q;

    // Oldest bit falls off the top, so any count works
    always_ff @(posedge mclk)
    begin
        if (reset)
            shreg_q <= SHREG_RESET;
        else if (sclk_rise)
            shreg_q <= {shreg_q[CFG_W-2:0], sync_q.serial_data};
    end

    // ==========================================
    // Configuration latches
    scl_src_t last_src_q;
    scl_cfg_t cfg_q;
    scl_cfg_t par_cfg;

    assign par_cfg = '{test: cfg_q.test, out_div: sync_q.out_div_pins,
        loop_div: sync_q.loop_div_pins};

    // Strobe that opened latest owns the latches when both are open
    always_ff @(posedge mclk)
    begin
        if (reset)
            last_src_q <= SRC_PARALLEL;
        else if (sync_q.serial_load && !sload_prev_q)
            last_src_q <= SRC_SERIAL;
        else if (!sync_q.parallel_load && pload_prev_q)
            last_src_q <= SRC_PARALLEL;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            cfg_q <= CFG_RESET;
        else if (ser_open && (!par_open || last_src_q == SRC_SERIAL))
            cfg_q <= scl_cfg_t'(shreg_q);
        else if (par_open)
            cfg_q <= par_cfg;
    end

    assign loop_div_out = cfg_q.loop_div;
    assign out_div_out = cfg_q.out_div;

    // ==========================================
    // Reference selection
    always_ff @(posedge mclk)
    begin
        if (reset)
            pll_reference <= 1'h0;
        else if (sync_q.ref_source_select)
            pll_reference <= sync_q.crystal_pins;
        else
            pll_reference <= sync_q.external_ref_in;
    end

    // ==========================================
    // Output divider, mclk stands in for the oscillator
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [SHIFT_W-1:0] shift_d;
    logic [SHIFT_W-1:0] shift_act_q;
    logic en_act_q;
    logic wrap;

    assign cnt_d = cnt_q + 8'h01;
    assign wrap = (cnt_q == CNT_WRAP);
    assign shift_d = div_shift(cfg_q.out_div) +
        (sync_q.slow_output_request ? SHIFT_SLOW : SHIFT_BY1);

    always_ff @(posedge mclk)
    begin
        if (reset)
            cnt_q <= CNT_ZERO;
        else
            cnt_q <= cnt_d;
    end

    // Every tap falls together at wrap, so changes there cut no pulse
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            en_act_q <= 1'h0;
            shift_act_q <= SHIFT_BY1;
        end
        else if (wrap)
        begin
            en_act_q <= sync_q.output_enable;
            shift_act_q <= shift_d;
        end
    end

    logic out_next;
    assign out_next = wrap ? 1'h0 : cnt_d[shift_act_q];

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            synth_clock_out <= 1'h0;
            synth_clock_out_n <= 1'h1;
        end
        else if (!en_act_q || wrap)
        begin
            synth_clock_out <= 1'h0;
            synth_clock_out_n <= 1'h1;
        end
        else
        begin
            synth_clock_out <= out_next;
            synth_clock_out_n <= ~out_next;
        end
    end

    // ==========================================
    // Test output
    always_ff @(posedge mclk)
    begin
        if (reset)
            test_out <= 1'h0;
        else
        begin
            unique case (cfg_q.test)
                TST_LOW: test_out <= 1'h0;
                TST_SHIFT_MSB: test_out <= shreg_q[CFG_W-1];
                TST_REFERENCE: test_out <= pll_reference;
                TST_OUT_CLOCK: test_out <= synth_clock_out;
                TST_LOOP_MSB: test_out <= cfg_q.loop_div[LOOP_W-1];
                TST_SOURCE: test_out <= last_src_q;
                TST_OSC: test_out <= cnt_q[0];
                TST_HIGH: test_out <= 1'h1;
            endcase
        end
    end

    // ==========================================
    // Assertions
    a_serial_shift: assert property (@(posedge mclk) disable iff (reset)
        sclk_rise |=> shreg_q == {$past(shreg_q[CFG_W-2:0]), $past(sync_q.serial_data)})
        else $error("serial shift register did not take data bit");

    a_serial_follow: assert property (@(posedge mclk) disable iff (reset)
        (ser_open && !par_open) |=> cfg_q == $past(shreg_q))
        else $error("serial latch not transparent while strobe high");

    a_parallel_follow: assert property (@(posedge mclk) disable iff (reset)
        (par_open && !ser_open) |=> cfg_q.loop_div == $past(sync_q.loop_div_pins)
            && cfg_q.out_div == $past(sync_q.out_div_pins))
        else $error("parallel latch not transparent while strobe low");

    a_latch_hold: assert property (@(posedge mclk) disable iff (reset)
        (!par_open && !ser_open) |=> $stable(cfg_q))
        else $error("configuration changed with both strobes closed");

    a_ref_select: assert property (@(posedge mclk) disable iff (reset)
        ##1 pll_reference == ($past(sync_q.ref_source_select) ?
            $past(sync_q.crystal_pins) : $past(sync_q.external_ref_in)))
        else $error("wrong reference source");

    a_enable_step: assert property (@(posedge mclk) disable iff (reset)
        $changed(en_act_q) |-> cnt_q == CNT_ZERO && !synth_clock_out)
        else $error("enable changed away from output boundary");

    a_disabled_level: assert property (@(posedge mclk) disable iff (reset)
        !$past(en_act_q) |-> !synth_clock_out && synth_clock_out_n)
        else $error("disabled output not held low and high");

    a_div_apply: assert property (@(posedge mclk) disable iff (reset)
        wrap |=> shift_act_q == $past(shift_d))
        else $error("divider setting not applied at wrap");

    a_undivided: assert property (@(posedge mclk) disable iff (reset)
        (en_act_q && shift_act_q == SHIFT_BY1 && !wrap && cnt_q != CNT_ZERO) ##1
            (en_act_q && !wrap) |-> synth_clock_out != $past(synth_clock_out))
        else $error("undivided output did not toggle");

endmodule

//--- hw/scl_pkg.sv
// Behaviour
// - Divider codes 00,01,10,11 divide 2,4,8,1
// - Parallel strobe copies loop and output divider pins
// - Parallel latch transparent low, holds at rising edge
// - Loop divider is seven bits, bit 6 MSB
// - Serial data shifts in on serial clock rise
// - Serial latch transparent high, holds at falling edge
// - Reference select 1 crystal, 0 external reference
// - Output enable active high, applied glitch free
// - Disabled output: true side low, complement high
// - Slow request divides output by sixteen synchronously
// - Oscillator 400 to 800 MHz feeds divider
// - Unconnected inputs default low or high per pin; the code loads these idle levels only during reset
// - Serial test field selects test output function
package scl_pkg;

    // ==========================================
    // Widths and field layout
    localparam int LOOP_W = 7;
    localparam int OUT_DIV_W = 2;
    localparam int TEST_W = 3;
    localparam int CFG_W = TEST_W + OUT_DIV_W + LOOP_W;
    localparam int CNT_W = 8;
    localparam int SHIFT_W = 3;

    // ==========================================
    // Oscillator range, informative for the analog side
    localparam int OSC_MIN_MHZ = 400;
    localparam int OSC_MAX_MHZ = 800;
    localparam int OUT_MIN_MHZ = 50;

    // ==========================================
    // Divider decode
    localparam logic [OUT_DIV_W-1:0] DIV_BY2 = 2'h0;
    localparam logic [OUT_DIV_W-1:0] DIV_BY4 = 2'h1;
    localparam logic [OUT_DIV_W-1:0] DIV_BY8 = 2'h2;
    localparam logic [OUT_DIV_W-1:0] DIV_BY1 = 2'h3;
    localparam logic [SHIFT_W-1:0] SHIFT_BY1 = 3'h0;
    localparam logic [SHIFT_W-1:0] SHIFT_BY2 = 3'h1;
    localparam logic [SHIFT_W-1:0] SHIFT_BY4 = 3'h2;
    localparam logic [SHIFT_W-1:0] SHIFT_BY8 = 3'h3;
    localparam logic [SHIFT_W-1:0] SHIFT_SLOW = 3'h4;
    localparam logic [CNT_W-1:0] CNT_WRAP = 8'hFF;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    // ==========================================
    // Test output selections
    localparam logic [TEST_W-1:0] TST_LOW = 3'h0;
    localparam logic [TEST_W-1:0] TST_SHIFT_MSB = 3'h1;
    localparam logic [TEST_W-1:0] TST_REFERENCE = 3'h2;
    localparam logic [TEST_W-1:0] TST_OUT_CLOCK = 3'h3;
    localparam logic [TEST_W-1:0] TST_LOOP_MSB = 3'h4;
    localparam logic [TEST_W-1:0] TST_SOURCE = 3'h5;
    localparam logic [TEST_W-1:0] TST_OSC = 3'h6;
    localparam logic [TEST_W-1:0] TST_HIGH = 3'h7;

    typedef struct packed {
        logic [TEST_W-1:0] test;
        logic [OUT_DIV_W-1:0] out_div;
        logic [LOOP_W-1:0] loop_div;
    } scl_cfg_t;

    // Reset state matches pulled-up divider pins
    localparam scl_cfg_t CFG_RESET = '{test: 3'h0, out_div: 2'h3, loop_div: 7'h7F};
    localparam logic [CFG_W-1:0] SHREG_RESET = 12'h000;

    typedef struct packed {
        logic serial_clock;
        logic serial_data;
        logic serial_load;
        logic parallel_load;
        logic [LOOP_W-1:0] loop_div_pins;
        logic [OUT_DIV_W-1:0] out_div_pins;
        logic output_enable;
        logic ref_source_select;
        logic external_ref_in;
        logic crystal_pins;
        logic slow_output_request;
    } scl_pins_t;

    // Pin idle levels: pulldowns low, pullups high
    localparam scl_pins_t PINS_IDLE = '{
        serial_clock: 1'h0, serial_data: 1'h0, serial_load: 1'h0,
        parallel_load: 1'h1, loop_div_pins: 7'h7F, out_div_pins: 2'h3,
        output_enable: 1'h1, ref_source_select: 1'h1, external_ref_in: 1'h0,
        crystal_pins: 1'h0, slow_output_request: 1'h0};

    typedef enum logic {
        SRC_PARALLEL = 1'h0,
        SRC_SERIAL = 1'h1
    } scl_src_t;

    function automatic logic [SHIFT_W-1:0] div_shift(input logic [OUT_DIV_W-1:0] code);
        logic [SHIFT_W-1:0] s;
        s = SHIFT_BY1;
        unique case (code)
            DIV_BY2: s = SHIFT_BY2;
            DIV_BY4: s = SHIFT_BY4;
            DIV_BY8: s = SHIFT_BY8;
            DIV_BY1: s = SHIFT_BY1;
        endcase
        return s;
    endfunction

endpackage

//--- testbench/scl_ctrl_model.sv
`timescale 1ns/1ps
// ==========================================
// Controller model driving the configuration pins
module scl_ctrl_model
    import scl_pkg::*;
(
    input wire logic mclk,
    output logic serial_clock,
    output logic serial_data,
    output logic serial_load,
    output logic parallel_load,
    output logic [LOOP_W-1:0] loop_div_pins,
    output logic [OUT_DIV_W-1:0] out_div_pins
);
    initial
    begin
        serial_clock = 1'h0;
        serial_data = 1'h0;
        serial_load = 1'h0;
        parallel_load = 1'h1;
        loop_div_pins = 7'h7F;
        out_div_pins = 2'h3;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // Two leading bits must be pushed out again
    task automatic shift_word(input logic [13:0] word);
        for (int i = 13; i >= 0; i--)
        begin
            serial_data = word[i];
            wait_n(3);
            serial_clock = 1'h1;
            wait_n(3);
            serial_clock = 1'h0;
        end
        wait_n(3);
        serial_data = 1'h0;
        serial_load = 1'h1;
        wait_n(6);
        serial_load = 1'h0;
        wait_n(3);
    endtask

    // Pins turned round after the rise to catch a latch that keeps following
    task automatic par_load(input logic [6:0] loop, input logic [1:0] div);
        loop_div_pins = loop;
        out_div_pins = div;
        parallel_load = 1'h0;
        wait_n(6);
        parallel_load = 1'h1;
        wait_n(4);
        loop_div_pins = ~loop;
        out_div_pins = ~div;
        wait_n(4);
    endtask
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import scl_pkg::*;
;
    logic mclk;
    logic reset;
    logic sc, sd, sl, pl, oe, rs, ext, xt, slow;
    logic [6:0] lp;
    logic [1:0] dp;
    scl_pins_t pins;
    logic [6:0] loop_o;
    logic [1:0] div_o;
    logic ref_o, fo, fo_n, tst;
    int fail_count = 0;
    int checks = 0;

    assign pins = {sc, sd, sl, pl, lp, dp, oe, rs, ext, xt, slow};
    always #10 mclk = ~mclk;

    scl_ctrl_model i_scl_ctrl_model (.mclk(mclk), .serial_clock(sc), .serial_data(sd),
        .serial_load(sl), .parallel_load(pl), .loop_div_pins(lp), .out_div_pins(dp));
    scl_config_logic i_scl_config_logic (.mclk(mclk), .reset(reset), .pins(pins),
        .loop_div_out(loop_o), .out_div_out(div_o), .pll_reference(ref_o),
        .synth_clock_out(fo), .synth_clock_out_n(fo_n), .test_out(tst));

    // ==========================================
    // Checking and closing
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Bounded wait; a stuck output ends the run through the report
    task automatic wait_rise(output int n);
        logic prev;
        logic seen;
        n = 0;
        seen = 1'h0;
        prev = fo;
        while (!seen && n < 700)
        begin
            @(negedge mclk);
            n++;
            seen = (prev === 1'h0 && fo === 1'h1);
            prev = fo;
        end
        if (!seen)
        begin
            check("output clock rise", 8'h00, 8'h01);
            finish_test();
        end
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        repeat (3) @(negedge mclk);
        check("reset loop", {1'h0, loop_o}, 8'h7F);
        check("reset div", {6'h00, div_o}, 8'h03);
        check("reset pair", {6'h00, fo, fo_n}, 8'h01);
        $display("reset test done");
    endtask

    task automatic t_config();
        i_scl_ctrl_model.shift_word({2'h3, 3'h7, 2'h0, 7'h2A});
        check("serial loop", {1'h0, loop_o}, 8'h2A);
        check("serial div", {6'h00, div_o}, 8'h00);
        check("test high", {7'h00, tst}, 8'h01);
        i_scl_ctrl_model.shift_word({2'h0, 3'h5, 2'h1, 7'h55});
        check("serial loop 2", {1'h0, loop_o}, 8'h55);
        check("serial div 2", {6'h00, div_o}, 8'h01);
        check("serial source", {7'h00, tst}, 8'h01);
        i_scl_ctrl_model.par_load(7'h0B, 2'h3);
        check("parallel loop", {1'h0, loop_o}, 8'h0B);
        check("parallel div", {6'h00, div_o}, 8'h03);
        check("parallel source", {7'h00, tst}, 8'h00);
        // Loop msb low here, so a source or high select would show 1
        i_scl_ctrl_model.shift_word({2'h0, 3'h4, 2'h2, 7'h3F});
        check("serial div 3", {6'h00, div_o}, 8'h02);
        check("test loop msb", {7'h00, tst}, 8'h00);
        $display("config test done");
    endtask

    task automatic t_ref();
        logic [2:0] tbl [3] = '{3'h6, 3'h2, 3'h3};
        for (int i = 0; i < 3; i++)
        begin
            {rs, ext, xt} = tbl[i];
            i_scl_ctrl_model.wait_n(6);
            check("reference", {7'h00, ref_o}, {7'h00, rs ? xt : ext});
        end
        $display("reference test done");
    endtask

    task automatic t_clock();
        logic [1:0] code [5] = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h3};
        int div [5] = '{1, 2, 4, 8, 16};
        int n;
        for (int i = 0; i < 5; i++)
        begin
            slow = (i == 4);
            i_scl_ctrl_model.par_load(7'h40, code[i]);
            i_scl_ctrl_model.wait_n(600);
            wait_rise(n);
            wait_rise(n);
            check("period", n[7:0], 8'(2 * div[i]));
            check("complement", {7'h00, fo_n}, {7'h00, ~fo});
        end
        oe = 1'h0;
        i_scl_ctrl_model.wait_n(600);
        check("disabled pair", {6'h00, fo, fo_n}, 8'h01);
        $display("clock test done");
    endtask

    initial
    begin
        mclk = 1'h0;
        reset = 1'h1;
        {oe, rs, ext, xt, slow} = 5'h18;
        repeat (2) @(negedge mclk);
        reset = 1'h0;
        t_reset();
        t_config();
        t_ref();
        t_clock();
        finish_test();
    end
endmodule
